// [design/rpsm_map.sv]
// Purpose: Remappable pin select map with an AXI4-Lite register slave.
// Assumes: All inputs except i_rst_b synchronous to i_ref_clk.
// Notes:   Function-to-peripheral table lives outside; this block only
//          reports the selected function code per pin.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module rpsm_map (
   input  wire logic        i_ref_clk,       // System clock
   input  wire logic        i_rst_b,         // Async reset, active low
   input  wire logic [5:0]  i_awaddr,        // AXI write address
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,         // AXI write data
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [5:0]  i_araddr,        // AXI read address
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   input  wire logic [25:0] i_remappable_pin_n,   // Pin input levels
   output logic             o_spi_slave_select_in, // To SPI module
   output logic [69:0]      o_pin_output_function, // 14 x 5-bit codes
   output logic [13:0]      o_pin_periph_owned     // Pin leaves port ctl
);

   // Selector storage, addressed by pin index
   logic [4:0]  spi_select_pin_choice;               // Input selector
   logic [4:0]  next_spi_select_pin_choice;
   logic [4:0]  out_sel      [0:13];                 // Output selectors
   logic [4:0]  next_out_sel [0:13];
   // Write channel capture; address and data may arrive in any order
   logic        aw_held, next_aw_held;
   logic        w_held,  next_w_held;
   logic [5:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data,  next_w_data;
   logic [3:0]  w_strb,  next_w_strb;
   logic        bvalid,  next_bvalid;
   logic [1:0]  bresp,   next_bresp;
   // Read channel
   logic        rvalid,  next_rvalid;
   logic [31:0] rdata,   next_rdata;
   logic [1:0]  rresp,   next_rresp;
   logic        ss_level, next_ss_level;             // Registered SS in

   // Maps a byte address to an output register index, or 7 for none
   function automatic logic [2:0] oreg_index(input logic [5:0] a);
      logic [5:0] d;
      d = a - rpsm_pkg::RPSM_OFS_OUT0;
      if (a >= rpsm_pkg::RPSM_OFS_OUT0 && d[1:0] == 2'h0 &&
          d[5:2] < 4'(rpsm_pkg::RPSM_NUM_OREG))
         oreg_index = d[4:2];
      else
         oreg_index = 3'h7;
   endfunction : oreg_index

   // Combined write happens once both halves are held
   logic       do_write;
   logic [2:0] wr_idx;
   assign do_write = aw_held && w_held && !bvalid;
   assign wr_idx   = oreg_index(aw_addr);

   // Handshake outputs are combinational on held state
   assign o_awready = !aw_held && !bvalid;
   assign o_wready  = !w_held && !bvalid;
   assign o_arready = !rvalid;
   assign o_bvalid  = bvalid;
   assign o_bresp   = bresp;
   assign o_rvalid  = rvalid;
   assign o_rdata   = rdata;
   assign o_rresp   = rresp;

   // Write path next state
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_spi_select_pin_choice = spi_select_pin_choice;
      for (int i = 0; i < 14; i++) begin
         next_out_sel[i] = out_sel[i];
      end
      // Capture each channel as it is offered
      if (i_awvalid && o_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         next_w_held = 1'b1;
         next_w_data = i_wdata;
         next_w_strb = i_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = rpsm_pkg::RPSM_RESP_OKAY;
         if (aw_addr == rpsm_pkg::RPSM_OFS_SS_IN) begin
            // Only the low five bits exist; others ignored
            if (w_strb[0]) begin
               next_spi_select_pin_choice = w_data[4:0];
            end
         end else if (wr_idx != 3'h7) begin
            // Even pin in byte 0, odd pin in byte 1; a lane without its
            // strobe keeps its selector, so one pin can change alone
            if (w_strb[0]) begin
               next_out_sel[2*wr_idx] =
                  w_data[rpsm_pkg::RPSM_EVEN_LSB +: 5];
            end
            if (w_strb[1]) begin
               next_out_sel[2*wr_idx+1] =
                  w_data[rpsm_pkg::RPSM_ODD_LSB +: 5];
            end
         end else if (aw_addr != rpsm_pkg::RPSM_OFS_STAT) begin
            next_bresp = rpsm_pkg::RPSM_RESP_SLVERR;  // Unmapped
         end
      end
      if (bvalid && i_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // Write path registers
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 6'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
         spi_select_pin_choice <= rpsm_pkg::RPSM_SS_RESET;
         for (int i = 0; i < 14; i++) begin
            out_sel[i] <= rpsm_pkg::RPSM_OUT_RESET;
         end
      end else begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         spi_select_pin_choice <= next_spi_select_pin_choice;
         for (int i = 0; i < 14; i++) begin
            out_sel[i] <= next_out_sel[i];
         end
      end
   end

   // Read path next state
   always_comb begin
      logic [2:0] ri;
      ri          = oreg_index(i_araddr);
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (i_arvalid && o_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = rpsm_pkg::RPSM_RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         if (i_araddr == rpsm_pkg::RPSM_OFS_SS_IN) begin
            next_rdata[4:0] = spi_select_pin_choice;
         end else if (ri != 3'h7) begin
            next_rdata[rpsm_pkg::RPSM_EVEN_LSB +: 5] = out_sel[2*ri];
            next_rdata[rpsm_pkg::RPSM_ODD_LSB +: 5] = out_sel[2*ri+1];
         end else if (i_araddr == rpsm_pkg::RPSM_OFS_STAT) begin
            next_rdata[0]    = ss_level;                   // Live state
            next_rdata[29:16] = o_pin_periph_owned;
         end else begin
            next_rresp = rpsm_pkg::RPSM_RESP_SLVERR;
         end
      end else if (rvalid && i_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // Slave-select routing: pin index or ground
   always_comb begin
      if (spi_select_pin_choice <= rpsm_pkg::RPSM_SEL_MAXPIN)
         next_ss_level = i_remappable_pin_n[spi_select_pin_choice];
      else
         next_ss_level = 1'b0;  // other unused codes also tie low
   end

   // Read path and routed input registers
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rvalid   <= 1'b0;
         rdata    <= 32'h0000_0000;
         rresp    <= 2'h0;
         ss_level <= 1'b0;
      end else begin
         rvalid   <= next_rvalid;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
         ss_level <= next_ss_level;
      end
   end
   assign o_spi_slave_select_in = ss_level;

   // Output function codes; zero means ordinary port control
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         o_pin_output_function[5*i +: 5] = out_sel[i];
         o_pin_periph_owned[i] = (out_sel[i] != 5'h00);
      end
   end

   // Assertions: write decode, routing and readback
   ss_ground_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      spi_select_pin_choice == rpsm_pkg::RPSM_SEL_GND
      |=> !o_spi_slave_select_in)
      else $error("slave select not tied low");
   // Codes past the last pin must never leak a pin level through
   code_high_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      spi_select_pin_choice > rpsm_pkg::RPSM_SEL_MAXPIN
      |=> !o_spi_slave_select_in)
      else $error("unused code not tied low");
   ss_route_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      spi_select_pin_choice <= rpsm_pkg::RPSM_SEL_MAXPIN
      |=> o_spi_slave_select_in ==
          $past(i_remappable_pin_n[spi_select_pin_choice]))
      else $error("slave select not routed from pin");
   ss_field_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      do_write && aw_addr == rpsm_pkg::RPSM_OFS_SS_IN && w_strb[0]
      |=> spi_select_pin_choice == $past(w_data[4:0]))
      else $error("input selector write lost");
   odd_field_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      do_write && wr_idx == 3'h0 && w_strb[1]
      |=> out_sel[1] == $past(w_data[12:8]))
      else $error("odd selector write lost");
   out_code_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      do_write && wr_idx == 3'h6 && w_strb[0]
      |=> o_pin_output_function[64:60] == $past(w_data[4:0]))
      else $error("pin output code not updated");
   // A lane without its strobe must keep the old selector
   strb_keep_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      do_write && wr_idx == 3'h1 && !w_strb[0]
      |=> out_sel[2] == $past(out_sel[2]))
      else $error("unstrobed selector changed");
   bad_addr_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      do_write && wr_idx == 3'h7 &&
      aw_addr != rpsm_pkg::RPSM_OFS_SS_IN &&
      aw_addr != rpsm_pkg::RPSM_OFS_STAT
      |=> o_bresp == rpsm_pkg::RPSM_RESP_SLVERR)
      else $error("unmapped write not refused");
   rd_zero_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_arvalid && o_arready && i_araddr != rpsm_pkg::RPSM_OFS_STAT
      |=> o_rdata[31:13] == 19'h0 && o_rdata[7:5] == 3'h0)
      else $error("unimplemented bits not zero");
   ss_read_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_arvalid && o_arready && i_araddr == rpsm_pkg::RPSM_OFS_SS_IN
      |=> o_rdata[4:0] == $past(spi_select_pin_choice) &&
          o_rdata[31:5] == 27'h000_0000)
      else $error("input selector readback wrong");
   rd_field_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_arvalid && o_arready && i_araddr == rpsm_pkg::RPSM_OFS_OUT0
      |=> o_rdata[4:0] == $past(out_sel[0]) &&
          o_rdata[12:8] == $past(out_sel[1]))
      else $error("output selector readback wrong");
   port_ctl_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      do_write && wr_idx == 3'h0 && w_strb[0] && w_data[4:0] == 5'h00
      |=> !o_pin_periph_owned[0])
      else $error("zero code not port control");
   // Checked without the disable so the released values are seen
   rst_val_a: assert property (
      @(posedge i_ref_clk)
      $rose(i_rst_b)
      |-> spi_select_pin_choice == rpsm_pkg::RPSM_SS_RESET &&
          out_sel[0] == rpsm_pkg::RPSM_OUT_RESET &&
          out_sel[13] == rpsm_pkg::RPSM_OUT_RESET)
      else $error("reset values wrong");
   wr_resp_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      do_write |=> o_bvalid)
      else $error("write response missing");
   // Main scenarios: bus traffic, ground code, top pin, refused write
   cv_write: cover property (@(posedge i_ref_clk) do_write);
   cv_read: cover property (@(posedge i_ref_clk) o_rvalid && i_rready);
   cv_gnd: cover property (@(posedge i_ref_clk)
      spi_select_pin_choice == rpsm_pkg::RPSM_SEL_GND);
   cv_pin25: cover property (@(posedge i_ref_clk)
      spi_select_pin_choice == rpsm_pkg::RPSM_SEL_MAXPIN);
   cv_slverr: cover property (@(posedge i_ref_clk)
      o_bvalid && o_bresp == rpsm_pkg::RPSM_RESP_SLVERR);

endmodule : rpsm_map

// [design/rpsm_pkg.sv]
// Purpose: Shared constants for the remappable pin select map block.
// Assumes: AXI4-Lite register access, 32-bit data, word aligned.
// Notes:   Offsets are byte addresses of 32-bit register slots.
package rpsm_pkg;
   localparam int          RPSM_NUM_PINS   = 26;     // Remappable pins
   localparam int          RPSM_NUM_OUT    = 14;     // Pins with output map
   localparam int          RPSM_NUM_OREG   = 7;      // Output map registers
   localparam int          RPSM_SEL_W      = 5;      // Selector width
   localparam int          RPSM_ADDR_W     = 6;      // Byte address width
   // Register byte offsets
   localparam logic [5:0]  RPSM_OFS_SS_IN  = 6'h00;  // Slave-select input map
   localparam logic [5:0]  RPSM_OFS_OUT0   = 6'h04;  // First output map reg
   localparam logic [5:0]  RPSM_OFS_STAT   = 6'h20;  // Live pin status
   // Field positions
   localparam int          RPSM_EVEN_LSB   = 0;      // Even pin field lsb
   localparam int          RPSM_ODD_LSB    = 8;      // Odd pin field lsb
   // Reset values
   localparam logic [4:0]  RPSM_SS_RESET   = 5'h1F;  // Input tied low
   localparam logic [4:0]  RPSM_OUT_RESET  = 5'h00;  // Port control
   // Selector codes
   localparam logic [4:0]  RPSM_SEL_MAXPIN = 5'h19;  // Highest pin index
   localparam logic [4:0]  RPSM_SEL_GND    = 5'h1F;  // Tie to ground
   // AXI responses
   localparam logic [1:0]  RPSM_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RPSM_RESP_SLVERR = 2'h2;
endpackage : rpsm_pkg

// [verification/rpsm_pads.sv]
// Purpose: Pad model for the remappable pins feeding the map.
// Assumes: The bench requests pad levels at a rising edge.
// Notes:   Registered so pad edges land just after a clock edge.
`timescale 1ns/1ns
module rpsm_pads (
   input  wire logic        i_ref_clk, // System clock
   input  wire logic        i_rst_b,   // Reset, active low
   input  wire logic [25:0] i_drive,   // Wanted pad levels
   output logic [25:0]      o_pad      // Levels seen at the pins
);
   logic [25:0] next_pad;              // Level for the next edge
   // Pads follow the request one edge later
   always_comb begin
      next_pad = i_drive;
   end
   // Pull-downs hold the pads low while in reset
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pad <= 26'h000_0000;
      end else begin
         o_pad <= next_pad;
      end
   end
endmodule : rpsm_pads

// [verification/remappable_pin_select_map_tb.sv]
// Purpose: Self-checking bench for the pin select map.
// Assumes: Bus answers come whenever the slave is ready.
// Notes:   Samples at the falling edge so nothing races the clock.
`timescale 1ns/1ns
module remappable_pin_select_map_tb;
   logic        clk, rst_b, awv, wv, bready, arv, rready; // Bus controls
   logic [5:0]  awaddr, araddr;     // Byte addresses
   logic [31:0] wdata;              // Write data
   logic [25:0] drive, pads;        // Pad request and level
   logic        awrdy, wrdy, bvalid, arrdy, rvalid, ss; // Slave outputs
   logic [3:0]  wstrb;              // Write lane strobes
   logic [1:0]  bresp, rresp, last_bresp; // Responses
   logic [31:0] rdata;              // Read data
   logic [69:0] func;               // Pin function codes
   logic [13:0] owned;              // Pins leaving port control
   int          failures, tests_run, cycles; // Tallies
   rpsm_map dut_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_awaddr(awaddr),
      .i_awvalid(awv), .o_awready(awrdy), .i_wdata(wdata),
      .i_wstrb(wstrb), .i_wvalid(wv), .o_wready(wrdy), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arv), .o_arready(arrdy), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_remappable_pin_n(pads), .o_spi_slave_select_in(ss),
      .o_pin_output_function(func), .o_pin_periph_owned(owned));
   rpsm_pads pads_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_drive(drive),
      .o_pad(pads));
   // Free-running 125 MHz clock
   always #4 clk = ~clk;
   // Compare and tally; unknowns never match
   task automatic check(input string what, input logic [69:0] exp,
                        input logic [69:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // One write; address and data offered together, each released when taken
   task automatic wr(input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'h3);
      logic at, wt, bt;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      bt = 1'b0;
      while (!bt) begin
         @(negedge clk);
         at = awv && awrdy;
         wt = wv && wrdy;
         bt = bvalid;
         last_bresp = bresp;
         @(posedge clk);
         if (at) awv <= 1'b0;
         if (wt) wv <= 1'b0;
      end
      bready <= 1'b0;
      // Let an edge pass so a following call never re-drives bready
      @(posedge clk);
   endtask : wr
   // One read; data and response taken at the falling edge that sees rvalid
   task automatic rd(input logic [5:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic at, rt;
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      rt = 1'b0;
      while (!rt) begin
         @(negedge clk);
         at = arv && arrdy;
         rt = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (at) arv <= 1'b0;
      end
      rready <= 1'b0;
      // Let an edge pass so a following call never re-drives rready
      @(posedge clk);
   endtask : rd
   // Set pads, wait through pad and map registers, judge the select input
   task automatic see_ss(input logic [25:0] v, input logic exp);
      drive <= v;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("ss_in", {69'h0, exp}, {69'h0, ss});
      @(posedge clk);
   endtask : see_ss
   // Reset state at pins and in every map register
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0]  r;
      @(negedge clk);
      check("ss_in", 70'h0, {69'h0, ss});
      check("functions", 70'h0, func);
      check("owned", 70'h0, {56'h0, owned});
      @(posedge clk);
      rd(6'h00, d, r);
      check("ss map", 70'h1F, {38'h0, d});
      for (int k = 0; k < 7; k++) begin
         rd(6'(4 * k + 4), d, r);
         check("out map", 70'h0, {38'h0, d});
      end
   endtask : t_reset
   // Every pin code both ways, then the ground code
   task automatic t_ss_sel();
      logic [31:0] d;
      logic [1:0]  r;
      for (int c = 0; c <= 25; c++) begin
         wr(6'h00, 32'hFFFF_FFE0 | 32'(c));
         rd(6'h00, d, r);
         check("ss map", 70'(c), {38'h0, d});
         see_ss(~(26'h1 << c), 1'b0);
         see_ss(26'h1 << c, 1'b1);
      end
      wr(6'h00, 32'h0000_001A);
      see_ss(26'h3FF_FFFF, 1'b0);
      wr(6'h00, 32'hFFFF_FFFF);
      check("bresp", 70'(rpsm_pkg::RPSM_RESP_OKAY), {68'h0, last_bresp});
      rd(6'h00, d, r);
      check("ss map", 70'h1F, {38'h0, d});
      see_ss(26'h3FF_FFFF, 1'b0);
   endtask : t_ss_sel
   // Two codes per register with junk in the unused bits
   task automatic t_out_sel();
      logic [31:0] d;
      logic [1:0]  r;
      logic [69:0] exp;
      for (int k = 0; k < 7; k++) begin
         wr(6'(4 * k + 4), 32'hFFFF_E0E0 | 32'((2 * k + 2) << 8 | 2 * k + 1));
         rd(6'(4 * k + 4), d, r);
         check("out map", 70'((2 * k + 2) << 8 | 2 * k + 1), {38'h0, d});
         exp[10 * k +: 10] = {5'(2 * k + 2), 5'(2 * k + 1)};
      end
      @(negedge clk);
      check("functions", exp, func);
      check("owned", 70'h3FFF, {56'h0, owned});
      @(posedge clk);
      wr(6'h04, 32'h0000_0000);
      @(negedge clk);
      check("owned", 70'h3FFC, {56'h0, owned});
      @(posedge clk);
      wr(6'h08, 32'h0000_1F1F, 4'h2);
      rd(6'h08, d, r);
      check("one lane", 70'h1F03, {38'h0, d});
   endtask : t_out_sel
   // Unmapped place gives an error and zero data
   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0]  r;
      rd(6'h24, d, r);
      check("rresp", 70'(rpsm_pkg::RPSM_RESP_SLVERR), {68'h0, r});
      check("rdata", 70'h0, {38'h0, d});
      wr(6'h24, 32'h0000_0001);
      check("bresp", 70'(rpsm_pkg::RPSM_RESP_SLVERR), {68'h0, last_bresp});
      wr(6'h20, 32'hFFFF_FFFF);
      check("bresp", 70'(rpsm_pkg::RPSM_RESP_OKAY), {68'h0, last_bresp});
      rd(6'h20, d, r);
      check("status", 70'h3FFC_0000, {38'h0, d});
      check("rresp", 70'(rpsm_pkg::RPSM_RESP_OKAY), {68'h0, r});
   endtask : t_unmapped
   // Report counts and the verdict, then stop
   task automatic give_verdict();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // Hang guard, far beyond the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      {clk, rst_b, awv, wv, bready, arv, rready} = 7'h00;
      {awaddr, araddr, wdata, drive, wstrb} = 74'h0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_ss_sel();
      t_out_sel();
      t_unmapped();
      give_verdict();
   end
endmodule : remappable_pin_select_map_tb
